// File: ldc_defs.svh
// Constants of the LED dimming core: offsets, field positions, resets, timing
`ifndef LDC_DEFS_SVH
`define LDC_DEFS_SVH
`define LDC_NUM_SINKS      18
`define LDC_A_INIT         12'h000
`define LDC_A_CFG1         12'h004
`define LDC_A_CFG2         12'h008
`define LDC_A_CFG3         12'h00c
`define LDC_A_STATUS       12'h010
`define LDC_A_CGAIN        12'h014
`define LDC_A_GPWM         12'h018
`define LDC_A_ONOFF        12'h01c
`define LDC_A_DGRP_LO      12'h020
`define LDC_A_DGRP_HI      12'h024
`define LDC_A_DGAIN_PAGE   4'h1
`define LDC_A_DUTY_PAGE    4'h2
`define LDC_F_RATE         2
`define LDC_F_ACTIVE       3
`define LDC_F_SCALE        1
`define LDC_F_UP           1
`define LDC_F_PEAK_LSB     4
`define LDC_RST_PEAK       3'h3
`define LDC_RST_CGAIN      7'h40
`define LDC_RST_DGAIN      8'h80
`define LDC_RST_GPWM       8'hff
`define LDC_RST_ONOFF      18'h3ffff
`define LDC_PCLK_MHZ       8'd125
`define LDC_OSC_MHZ        8'd32
`define LDC_PHASE_NS       125
`define LDC_PHASE_TICKS    (((`LDC_PHASE_NS) * 32 + 999) / 1000)
`define LDC_TOP_FAST       9'h0ff
`define LDC_TOP_SLOW       9'h1ff
`define LDC_CUR_DIV        32'd32385
`endif

// File: ldc_pkg.sv
// Types of the LED dimming core
package ldc_pkg;
    typedef enum logic [1:0] {MODE_INSTANT, MODE_FRAME8, MODE_FRAME16, MODE_SPARE} ldc_mode_t;
    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [31:0]       prdata;
        ldc_mode_t         mode;
        logic              rate;
        logic              active;
        logic              act_prev;
        logic              phase_en;
        logic              scale_exp;
        logic [2:0][1:0]   comp;
        logic              dn_stage;
        logic              up_stage;
        logic [2:0]        peak_stage;
        logic              dn_pend;
        logic              up_pend;
        logic [2:0]        peak_pend;
        logic              dn_app;
        logic              up_app;
        logic [2:0]        peak_app;
        logic [2:0][6:0]   cgain;
        logic [2:0][7:0]   gpwm;
        logic [7:0]        glob;
        logic [17:0]       onoff;
        logic [17:0][1:0]  dgrp;
        logic [17:0][7:0]  dgain;
        logic [17:0][15:0] duty;
        logic [6:0]        acc;
        logic              tick;
        logic [8:0]        pcnt;
        logic [7:0]        sub;
        logic [4:0]        ch;
        logic [1:0]        ph;
        logic [17:0][15:0] fin;
        logic [17:0][15:0] cur;
        logic [17:0]       sink_on;
    } ldc_state_t;
endpackage : ldc_pkg

// File: ldc_core.sv
// LED dimming core: APB registers, current gain and PWM generation for 18 sinks
//
// Function
// - Peak code maps to eight sink maxima
// - Peak code resets to the 15 mA code
// - Instant mode applies peak code at once
// - Frame modes latch while inactive, apply on enable
// - Ghost enables follow the peak code timing
// - Three 7-bit colour gains, reset 64
// - Colour group is sink index modulo three
// - 8-bit dot gain per sink, reset 128
// - Current is peak times colour times dot
// - Per-dot duty, 16-bit via spread spectrum
// - 2-bit group select, 00 means none
// - Each group owns an 8-bit duty
// - One global 8-bit duty scales all
// - Final duty is product of three duties
// - PWM at 125 kHz or 62.5 kHz
// - Rate bit one selects 62.5 kHz
// - Timing from a 32 MHz oscillator tick
// - Optional 125 ns stagger across three phases
// - Three low-brightness compensation settings by phase
// - Linear or exponential duty scale
// - One on/off bit per dot
// - 16-bit duty only in third mode
//
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps
`include "ldc_defs.svh"

module ldc_core import ldc_pkg::*; (
    // Clock and reset
    input  wire logic                pclk,
    input  wire logic                presetn,
    // APB slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic                     pready,
    output logic [31:0]              prdata,
    output logic                     pslverr,
    // Sink drive
    output logic [17:0]              sink_on,
    output logic [17:0][15:0]        sink_current_ua,
    output logic [2:0]               peak_current_code,
    output logic                     up_deghost_en,
    output logic                     down_deghost_en
);

    ////////////////////////////////////////////////////////////////////////////
    ldc_state_t st_q;
    ldc_state_t st_d;

    function automatic logic [15:0] peak_ua(input logic [2:0] code);
        case (code)
            3'h0:    peak_ua = 16'd3000;
            3'h1:    peak_ua = 16'd5000;
            3'h2:    peak_ua = 16'd10000;
            3'h3:    peak_ua = 16'd15000;
            3'h4:    peak_ua = 16'd20000;
            3'h5:    peak_ua = 16'd30000;
            3'h6:    peak_ua = 16'd40000;
            default: peak_ua = 16'd50000;
        endcase
    endfunction : peak_ua

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        logic        setup;
        logic        wr;
        logic [4:0]  idx;
        logic [15:0] ind;
        logic [7:0]  gd;
        logic [15:0] f1;
        logic [15:0] f2;
        logic [15:0] fl;
        logic [31:0] prod;
        logic [8:0]  shift;
        logic [8:0]  pos;
        logic [9:0]  w;
        logic [7:0]  rv8;
        logic [6:0]  rv7;
        logic [7:0]  acc8;
        setup = psel && !penable && !st_q.pready;
        wr    = psel && penable && st_q.pready && pwrite;
        idx   = paddr[6:2];
        ind   = '0;
        gd    = '0;
        f1    = '0;
        f2    = '0;
        fl    = '0;
        prod  = '0;
        shift = '0;
        pos   = '0;
        w     = '0;
        rv8   = {<<{st_q.sub}};
        rv7   = {<<{st_q.sub[6:0]}};
        acc8  = '0;
        st_d  = st_q;

        // Bus answers one cycle after setup, so no access has a wait state
        st_d.pready  = setup;
        st_d.pslverr = 1'b0;
        st_d.prdata  = '0;
        if (setup) begin
            case (paddr)
                `LDC_A_INIT:    st_d.prdata = {28'h0, st_q.active, st_q.rate, st_q.mode};
                `LDC_A_CFG1:    st_d.prdata = {30'h0, st_q.scale_exp, st_q.phase_en};
                `LDC_A_CFG2:    st_d.prdata = {26'h0, st_q.comp};
                `LDC_A_CFG3:    st_d.prdata = {25'h0, st_q.peak_stage, 2'h0,
                                               st_q.up_stage, st_q.dn_stage};
                `LDC_A_STATUS:  st_d.prdata = {26'h0, st_q.active, st_q.up_app,
                                               st_q.dn_app, st_q.peak_app};
                `LDC_A_CGAIN:   st_d.prdata = {9'h0, st_q.cgain[2], 1'b0, st_q.cgain[1],
                                               1'b0, st_q.cgain[0]};
                `LDC_A_GPWM:    st_d.prdata = {st_q.glob, st_q.gpwm[2], st_q.gpwm[1],
                                               st_q.gpwm[0]};
                `LDC_A_ONOFF:   st_d.prdata = {14'h0, st_q.onoff};
                `LDC_A_DGRP_LO: st_d.prdata = st_q.dgrp[15:0];
                `LDC_A_DGRP_HI: st_d.prdata = {28'h0, st_q.dgrp[17:16]};
                default: begin
                    if (paddr[11:8] == `LDC_A_DGAIN_PAGE && paddr[7] == 1'b0
                        && idx < 5'd18) begin
                        st_d.prdata = {24'h0, st_q.dgain[idx]};
                    end else if (paddr[11:8] == `LDC_A_DUTY_PAGE && paddr[7] == 1'b0
                                 && idx < 5'd18) begin
                        st_d.prdata = {16'h0, st_q.duty[idx]};
                    end else begin
                        st_d.pslverr = 1'b1;
                    end
                end
            endcase
        end

        // Writes land on the completing access edge only
        if (wr && !st_q.pslverr) begin
            case (paddr)
                `LDC_A_INIT: begin
                    st_d.mode   = ldc_mode_t'(pwdata[1:0]);
                    st_d.rate   = pwdata[`LDC_F_RATE];
                    st_d.active = pwdata[`LDC_F_ACTIVE];
                end
                `LDC_A_CFG1: begin
                    st_d.phase_en  = pwdata[0];
                    st_d.scale_exp = pwdata[`LDC_F_SCALE];
                end
                `LDC_A_CFG2:    st_d.comp = pwdata[5:0];
                `LDC_A_CFG3: begin
                    st_d.dn_stage   = pwdata[0];
                    st_d.up_stage   = pwdata[`LDC_F_UP];
                    st_d.peak_stage = pwdata[`LDC_F_PEAK_LSB +: 3];
                end
                `LDC_A_CGAIN: begin
                    st_d.cgain[0] = pwdata[6:0];
                    st_d.cgain[1] = pwdata[14:8];
                    st_d.cgain[2] = pwdata[22:16];
                end
                `LDC_A_GPWM: begin
                    st_d.gpwm = pwdata[23:0];
                    st_d.glob = pwdata[31:24];
                end
                `LDC_A_ONOFF:   st_d.onoff = pwdata[17:0];
                `LDC_A_DGRP_LO: st_d.dgrp[15:0] = pwdata;
                `LDC_A_DGRP_HI: st_d.dgrp[17:16] = pwdata[3:0];
                default: begin
                    // Read-only status and other words fall through untouched
                    // dot gain or duty per sink
                    if (paddr[11:8] == `LDC_A_DGAIN_PAGE) begin
                        st_d.dgain[idx] = pwdata[7:0];
                    end else if (paddr[11:8] == `LDC_A_DUTY_PAGE) begin
                        st_d.duty[idx] = pwdata[15:0];
                    end
                end
            endcase
        end

        // frame modes take staged values only while inactive
        st_d.act_prev = st_q.active;
        if (st_q.mode == MODE_INSTANT || !st_q.active) begin
            st_d.peak_pend = st_q.peak_stage;
            st_d.dn_pend   = st_q.dn_stage;
            st_d.up_pend   = st_q.up_stage;
        end
        if (st_q.mode == MODE_INSTANT) begin
            st_d.peak_app = st_q.peak_stage;
            st_d.dn_app   = st_q.dn_stage;
            st_d.up_app   = st_q.up_stage;
        end else if (st_q.active && !st_q.act_prev) begin
            st_d.peak_app = st_q.peak_pend;
            st_d.dn_app   = st_q.dn_pend;
            st_d.up_app   = st_q.up_pend;
        end

        // fractional divider gives a 32 MHz tick from pclk
        acc8 = {1'b0, st_q.acc} + `LDC_OSC_MHZ;
        if (acc8 >= `LDC_PCLK_MHZ) begin
            st_d.acc  = 7'(acc8 - `LDC_PCLK_MHZ);
            st_d.tick = 1'b1;
        end else begin
            st_d.acc  = acc8[6:0];
            st_d.tick = 1'b0;
        end
        // period of 256 or 512 oscillator ticks
        if (st_q.tick) begin
            // rate bit picks the longer period
            if (st_q.pcnt == (st_q.rate ? `LDC_TOP_SLOW : `LDC_TOP_FAST)) begin
                st_d.pcnt = '0;
                st_d.sub  = st_q.sub + 8'h01;
            end else begin
                st_d.pcnt = st_q.pcnt + 9'h001;
            end
        end

        // One sink per cycle: duty product and current, so one set of multipliers
        st_d.ch = (st_q.ch == 5'd17) ? 5'd0 : st_q.ch + 5'd1;
        st_d.ph = (st_q.ph == 2'd2) ? 2'd0 : st_q.ph + 2'd1;
        // 8-bit modes spread the byte across 16 bits
        ind = (st_q.mode == MODE_FRAME16) ? st_q.duty[st_q.ch]
                                          : {2{st_q.duty[st_q.ch][7:0]}};
        // group select, none means full scale
        gd  = (st_q.dgrp[st_q.ch] == 2'b00) ? 8'hff : st_q.gpwm[st_q.dgrp[st_q.ch] - 2'd1];
        f1  = 16'((25'(ind) * 25'({1'b0, gd} + 9'h001)) >> 8);
        f2  = 16'((25'(f1) * 25'({1'b0, st_q.glob} + 9'h001)) >> 8);
        // fixed square curve as the exponential scale
        if (st_q.scale_exp) begin
            f2 = 16'((32'(f2) * 32'(f2)) >> 16);
        end
        // Floor only lifts dots that would vanish, never dark ones
        // compensation floor for dim but lit dots
        fl = {8'h00, st_q.comp[st_q.ph], 6'h00};
        if (f2 != 16'h0000 && f2 < fl) begin
            f2 = fl;
        end
        st_d.fin[st_q.ch] = f2;
        // peak times colour and dot ratios
        // colour group by index modulo three
        prod = 32'(peak_ua(st_q.peak_app)) * 32'(st_q.cgain[st_q.ph])
               * 32'(st_q.dgain[st_q.ch]);
        st_d.cur[st_q.ch] = 16'(prod / `LDC_CUR_DIV);

        for (int i = 0; i < `LDC_NUM_SINKS; i++) begin
            shift = st_q.phase_en ? 9'((i % 3) * `LDC_PHASE_TICKS) : 9'h000;
            pos   = st_q.pcnt - shift;
            // low bits stretch chosen sub-periods, bit-reversed order
            if (st_q.rate) begin
                w = {1'b0, st_q.fin[i][15:7]} + 10'(rv7 < st_q.fin[i][6:0]);
            end else begin
                pos = {1'b0, pos[7:0]};
                w   = {2'b00, st_q.fin[i][15:8]} + 10'(rv8 < st_q.fin[i][7:0]);
            end
            // on/off and enable gate the sink
            st_d.sink_on[i] = st_q.onoff[i] && st_q.active && ({1'b0, pos} < w);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q            <= '0;
            st_q.peak_stage <= `LDC_RST_PEAK;
            st_q.peak_pend  <= `LDC_RST_PEAK;
            st_q.peak_app   <= `LDC_RST_PEAK;
            st_q.cgain      <= {3{`LDC_RST_CGAIN}};
            st_q.dgain      <= {18{`LDC_RST_DGAIN}};
            st_q.gpwm       <= {3{`LDC_RST_GPWM}};
            st_q.glob       <= `LDC_RST_GPWM;
            st_q.onoff      <= `LDC_RST_ONOFF;
        end else begin
            st_q <= st_d;
        end
    end

    assign pready          = st_q.pready;
    assign prdata          = st_q.prdata;
    assign pslverr         = st_q.pslverr;
    assign sink_on         = st_q.sink_on;
    assign sink_current_ua = st_q.cur;
    assign peak_current_code = st_q.peak_app;
    assign up_deghost_en   = st_q.up_app;
    assign down_deghost_en = st_q.dn_app;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_instant_peak: assert property (st_q.mode == MODE_INSTANT |=>
        st_q.peak_app == $past(st_q.peak_stage)) else $error("peak code not applied");
    a_instant_ghost: assert property (st_q.mode == MODE_INSTANT |=>
        st_q.up_app == $past(st_q.up_stage) && st_q.dn_app == $past(st_q.dn_stage))
        else $error("ghost enables not applied");
    // The first active cycle still applies the pending code, so holding starts after it
    a_frame_hold: assert property ((st_q.mode != MODE_INSTANT && st_q.active
        && st_q.act_prev) ##1 (st_q.mode != MODE_INSTANT && st_q.active)
        |-> $stable(st_q.peak_app)) else $error("peak code changed while active");
    a_frame_apply: assert property (st_q.mode != MODE_INSTANT && $rose(st_q.active)
        |=> st_q.peak_app == $past(st_q.peak_pend)) else $error("pending peak lost");
    a_onoff_gate: assert property ((st_q.sink_on & ~$past(st_q.onoff)) == 18'h0)
        else $error("disabled dot driven");
    a_inactive_dark: assert property (!st_q.active |=> st_q.sink_on == 18'h0)
        else $error("sink on while inactive");
    a_tick_spacing: assert property (st_q.tick |=> !st_q.tick ##1 !st_q.tick)
        else $error("oscillator tick too fast");
    a_period_wrap: assert property (st_q.tick && st_q.pcnt == `LDC_TOP_FAST
        && !st_q.rate |=> st_q.pcnt == 9'h000) else $error("fast period wrong");
    a_bus_answer: assert property (psel && !penable && !st_q.pready |=> pready)
        else $error("no bus answer");

    // Read data and errors only ever stand beside ready, for one cycle
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data without ready");
    a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error without ready");
    // Status is read-only: a write there must not reach the dot duties
    a_ro_status: assert property (psel && penable && pready && pwrite
        && paddr == `LDC_A_STATUS |=> $stable(st_q.duty))
        else $error("status write landed");
    a_tick_gap: assert property (st_q.tick ##1 !st_q.tick [*3] |=> st_q.tick)
        else $error("oscillator tick too slow");
    a_slow_wrap: assert property (st_q.tick && st_q.pcnt == `LDC_TOP_SLOW
        && st_q.rate |=> st_q.pcnt == 9'h000) else $error("slow period wrong");

    c_write: cover property (psel && penable && pready && pwrite);
    c_enable: cover property (st_q.mode == MODE_FRAME16 && $rose(st_q.active));
    c_sink_lit: cover property (st_q.sink_on[17] && st_q.phase_en);
    c_comp_lit: cover property (st_q.comp[0] != 2'b00 && st_q.sink_on[0]);
    c_slow_lit: cover property (st_q.rate && st_q.sink_on[0]);

endmodule : ldc_core

// File: ldc_dots.sv
// Partner model: eighteen LED dots on the current sinks, measuring light per dot
`timescale 1ns/1ps

module ldc_dots (
    // Clock and reset
    input  wire logic              pclk,
    input  wire logic              presetn,
    // Sink drive
    input  wire logic [17:0]       sink_on,
    input  wire logic [17:0][15:0] sink_current_ua,
    // Measurement
    input  wire logic              clear,
    output logic [17:0][15:0]      lit_cnt,
    output logic [17:0][7:0]       rise_cnt,
    output logic [17:0][31:0]      rise_at
);
    logic [31:0] now_q;
    logic [17:0] lit_q;
    logic [17:0] glow;

    ////////////////////////////////////////////////////////////////////////////
    // A dot only glows while its sink conducts a nonzero current
    always_comb begin
        for (int i = 0; i < 18; i++) begin
            glow[i] = sink_on[i] && (sink_current_ua[i] != 16'h0000);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            now_q    <= 32'h0000_0000;
            lit_q    <= '0;
            lit_cnt  <= '0;
            rise_cnt <= '0;
            rise_at  <= '0;
        end else begin
            now_q <= now_q + 32'h0000_0001;
            lit_q <= glow;
            for (int i = 0; i < 18; i++) begin
                if (clear) begin
                    lit_cnt[i]  <= 16'h0000;
                    rise_cnt[i] <= 8'h00;
                end else begin
                    if (glow[i]) begin
                        lit_cnt[i] <= lit_cnt[i] + 16'h0001;
                    end
                    if (glow[i] && !lit_q[i]) begin
                        rise_cnt[i] <= rise_cnt[i] + 8'h01;
                        rise_at[i]  <= now_q;
                    end
                end
            end
        end
    end
endmodule : ldc_dots

// File: ldc_core_bench.sv
// Testbench of the LED dimming core: APB register checks and measured sink light
`timescale 1ns/1ps
`include "ldc_defs.svh"

module ldc_core_bench;
    logic                pclk    = 1'b0;
    logic                presetn = 1'b0;
    logic                psel    = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite  = 1'b0;
    logic [11:0]         paddr   = 12'h000;
    logic [31:0]         pwdata  = 32'h0000_0000;
    logic                clear   = 1'b0;
    logic                pready;
    logic [31:0]         prdata;
    logic                pslverr;
    logic [17:0]         sink_on;
    logic [17:0][15:0]   sink_current_ua;
    logic [2:0]          peak_current_code;
    logic                up_deghost_en;
    logic                down_deghost_en;
    logic [17:0][15:0]   lit_cnt;
    logic [17:0][7:0]    rise_cnt;
    logic [17:0][31:0]   rise_at;
    logic [31:0]         rd;
    logic                er;
    int                  errors      = 0;
    int                  checks_done = 0;

    localparam int PK_UA [8] = '{3000, 5000, 10000, 15000, 20000, 30000, 40000, 50000};
    localparam int CG [3]    = '{1, 32, 127};
    // Light cases: plain, slow, exponential, group, global, off, 16-bit, 8-bit, stagger, comp
    localparam logic [31:0] T_INIT [10]  = '{8, 12, 8, 8, 8, 8, 10, 8, 8, 10};
    localparam logic [31:0] T_CFG1 [10]  = '{0, 0, 2, 0, 0, 0, 0, 0, 1, 0};
    localparam logic [31:0] T_GRP [10]   = '{0, 0, 0, 5, 0, 0, 0, 0, 0, 0};
    localparam logic [31:0] T_GPWM [10]  = '{'1, '1, '1, 32'hffff_ff7f, 32'h3fff_ffff,
                                             '1, '1, '1, '1, '1};
    localparam logic [31:0] T_ONOFF [10] = '{'1, '1, '1, '1, '1, 32'h0003_fffc, '1, '1, '1,
                                             '1};
    localparam logic [31:0] T_DUTY [10]  = '{32'h80, 32'h80, 32'h80, 32'h80, 32'h80, 32'h80,
                                             32'h4000, 32'h4000, 32'h80, 32'h1};
    localparam int T_PM [10]   = '{502, 502, 252, 251, 125, 0, 250, 0, 502, 3};
    localparam int T_RISE [10] = '{6, 3, 6, 6, 6, 0, 6, 0, 6, 4};
    localparam int T_LAG [10]  = '{0, 0, 0, 0, 0, -1, 0, -1, 16, -1};

    ldc_core ldc_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .sink_on(sink_on), .sink_current_ua(sink_current_ua),
        .peak_current_code(peak_current_code), .up_deghost_en(up_deghost_en),
        .down_deghost_en(down_deghost_en));

    ldc_dots ldc_dots_inst (.pclk(pclk), .presetn(presetn), .sink_on(sink_on),
        .sink_current_ua(sink_current_ua), .clear(clear), .lit_cnt(lit_cnt),
        .rise_cnt(rise_cnt), .rise_at(rise_at));

    initial begin
        forever begin
            #4 pclk = ~pclk;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : complete_run

    // Master holds the request until pready is seen at a rising edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16 && pready !== 1'b1; n++) begin
            @(posedge pclk);
        end
        if (n == 16) begin
            errors++;
            complete_run();
        end
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", nm, exp, got);
        end
    endtask : check

    task automatic near(input string nm, input int exp, input logic [31:0] got, input int tol);
        checks_done++;
        if ((got + tol >= exp && got <= exp + tol) !== 1'b1) begin
            errors++;
            $display("unexpected %s expected %0d seen %0d", nm, exp, got);
        end
    endtask : near

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
        xfer(1'b0, a, 32'h0000_0000);
        check(nm, exp, rd);
    endtask : rdchk

    function automatic logic [31:0] cur_ua(input int c, input int cg, input int dg);
        return 32'((PK_UA[c] * cg * dg) / 32385);
    endfunction : cur_ua

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (20) @(posedge pclk);
        check("peak code", 32'h3, 32'(peak_current_code));
        rdchk(`LDC_A_STATUS, 32'h0000_0003, "status");
        xfer(1'b1, `LDC_A_STATUS, 32'hffff_ffff);
        rdchk(12'h210, 32'h0000_0000, "duty after status write");
        rdchk(`LDC_A_CGAIN, 32'h0040_4040, "colour gain");
        rdchk(`LDC_A_GPWM, 32'hffff_ffff, "pwm duties");
        rdchk(12'h144, 32'h0000_0080, "dot gain");
        rdchk(`LDC_A_ONOFF, 32'h0003_ffff, "on off");
        rdchk(`LDC_A_DGRP_HI, 32'h0000_0000, "dot group");
        rdchk(12'h0f0, 32'h0000_0000, "unmapped read");
        check("slave error", 32'h1, 32'(er));
        for (int i = 0; i < 18; i++) begin
            check("current", cur_ua(3, 64, 128), 32'(sink_current_ua[i]));
        end
        for (int c = 0; c < 8; c++) begin
            xfer(1'b1, `LDC_A_CFG3, 32'((c << 4) | (~c & 3)));
            repeat (20) @(posedge pclk);
            check("applied peak", 32'(c), 32'(peak_current_code));
            check("instant ghost", 32'(~c & 3), 32'({up_deghost_en, down_deghost_en}));
            check("peak current", cur_ua(c, 64, 128), 32'(sink_current_ua[17]));
        end
        xfer(1'b1, `LDC_A_CGAIN, 32'h007f_2001);
        xfer(1'b1, 12'h110, 32'h0000_00ff);
        repeat (20) @(posedge pclk);
        for (int i = 0; i < 18; i++) begin
            check("sink current", cur_ua(7, CG[i % 3], i == 4 ? 255 : 128),
                  32'(sink_current_ua[i]));
        end
        // Frame mode defers peak and ghost settings until activation
        xfer(1'b1, `LDC_A_INIT, 32'h0000_0001);
        xfer(1'b1, `LDC_A_CFG3, 32'h0000_0023);
        repeat (5) @(posedge pclk);
        check("held peak", 32'h7, 32'(peak_current_code));
        check("held ghost", 32'h0, 32'({up_deghost_en, down_deghost_en}));
        xfer(1'b1, `LDC_A_INIT, 32'h0000_0009);
        xfer(1'b1, `LDC_A_CFG3, 32'h0000_0050);
        repeat (5) @(posedge pclk);
        check("new peak", 32'h2, 32'(peak_current_code));
        check("new ghost", 32'h3, 32'({up_deghost_en, down_deghost_en}));
        xfer(1'b1, `LDC_A_INIT, 32'h0000_0001);
        xfer(1'b1, `LDC_A_INIT, 32'h0000_0009);
        repeat (5) @(posedge pclk);
        check("later peak", 32'h5, 32'(peak_current_code));
        check("later ghost", 32'h0, 32'({up_deghost_en, down_deghost_en}));
        // Settings go in while inactive so every mode sees them applied together
        for (int k = 0; k < 10; k++) begin
            xfer(1'b1, `LDC_A_INIT, T_INIT[k] & 32'hffff_fff7);
            xfer(1'b1, `LDC_A_CFG1, T_CFG1[k]);
            xfer(1'b1, `LDC_A_CFG2, k == 9 ? 32'h0000_0003 : 32'h0000_0000);
            xfer(1'b1, `LDC_A_DGRP_LO, T_GRP[k]);
            xfer(1'b1, `LDC_A_GPWM, T_GPWM[k]);
            xfer(1'b1, `LDC_A_ONOFF, T_ONOFF[k]);
            xfer(1'b1, 12'h200, T_DUTY[k]);
            xfer(1'b1, 12'h204, T_DUTY[k]);
            xfer(1'b1, `LDC_A_INIT, T_INIT[k]);
            repeat (2100) @(posedge pclk);
            clear <= 1'b1;
            @(posedge pclk);
            clear <= 1'b0;
            repeat (6000) @(posedge pclk);
            near("lit share", T_PM[k], 32'(lit_cnt[0] / 6), 15);
            near("pwm periods", T_RISE[k], 32'(rise_cnt[0]), 1);
            if (T_LAG[k] >= 0) begin
                near("phase lag", T_LAG[k], rise_at[1] - rise_at[0], 2);
            end
        end
        complete_run();
    end
endmodule : ldc_core_bench
